//--- inc/shaft_position_feedback_consts.svh
// Purpose: Constants of the shaft position feedback block.
// Assumes: Clock of 100 MHz; angles in units of 0.0001 degree.
// Notes: Speed scaling is tied to the documented measuring window.
`ifndef SHAFT_POSITION_FEEDBACK_CONSTS_SVH
`define SHAFT_POSITION_FEEDBACK_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define KIND_DEFAULT 4'h3
`define KIND_LAST 4'h9
`define LINES_MIN 18'h000FA
`define LINES_MAX 18'h3FFFF
`define LINES_DEFAULT 18'h00800
`define EDGES_PER_LINE 4
`define DEG_FULL 22'h36EE80
`define GEAR_DEFAULT 32'h00000001
`define GEAR_IN_MIN 32'h00000001
`define GEAR_LIMIT 32'h77359400
`define ABS_TURN_BITS 12
`define TURN_BITS 32
`define SPEED_WINDOW_NS 10000000
`define SPEED_WINDOW_CYC (`SPEED_WINDOW_NS / `CLK_PERIOD_NS)
`define WINDOWS_PER_SEC (1000000000 / `SPEED_WINDOW_NS)
`define RPM_FACTOR (`WINDOWS_PER_SEC * 60 * 100)
`define HZ_FACTOR (`WINDOWS_PER_SEC * 100)
`define FILTER_CYC 3
`define ALIGN_TRIES 3
`define ALIGN_TOL 8
`define CODE_NOT_REQUIRED 4'h0
`define CODE_DRIVE_RUNNING 4'h1
`define CODE_MOTOR_MOVING 4'h2
`define CODE_SENSOR_FAULT 4'h3
`define CODE_IN_PROGRESS 4'h4
`define CODE_IDENTIFYING 4'h5
`define CODE_COMPLETED 4'h6
`define CODE_LOST 4'h7
`define CODE_FAILED 4'h8
`define CODE_WARNING 4'h9
`define CARD_NONE 2'h0
`define CARD_PULSE 2'h1
`define CARD_ANALOG 2'h2
`define CARD_RESOLVER 2'h3
`endif

//--- inc/shaft_position_feedback_pkg.sv
// Purpose: Types of the shaft position feedback block.
// Assumes: Nothing beyond the constants header.
// Notes: Alignment states follow a Gray sequence along the usual path.
package shaft_position_feedback_pkg;
    typedef enum logic [3:0] {
        KIND_QUAD_SE = 4'h0,
        KIND_CLKDIR_SE = 4'h1,
        KIND_CLK_SE = 4'h2,
        KIND_QUAD_DIFF = 4'h3,
        KIND_CLKDIR_DIFF = 4'h4,
        KIND_CLK_DIFF = 4'h5,
        KIND_SINCOS_INC = 4'h6,
        KIND_ABS_SINGLE = 4'h7,
        KIND_ABS_MULTI = 4'h8,
        KIND_RESOLVER = 4'h9
    } sensor_kind_t;
    typedef enum logic [2:0] {
        AL_OFF = 3'h0,
        AL_CHECK = 3'h1,
        AL_RUN = 3'h3,
        AL_VERIFY = 3'h2,
        AL_DONE = 3'h6,
        AL_FAIL = 3'h7
    } align_fsm_t;
    typedef enum logic [2:0] {
        JOB_ANGLE = 3'h0,
        JOB_LOAD_DIV = 3'h1,
        JOB_LOAD_MOD = 3'h2,
        JOB_RPM = 3'h3,
        JOB_HZ = 3'h4
    } div_job_t;
endpackage : shaft_position_feedback_pkg

//--- hdl/shaft_position_feedback.sv
// Purpose: Shaft sensor decoding, position, turns, speed and alignment.
// Assumes: Settings arrive as levels and are taken on cfgWrite.
// Notes: One serial divider is shared by all angle and speed results.
// Contract
// - Sensor kind 0 to 9, default 3.
// - Flag kind not matching fitted hardware.
// - Lines setting 250..262143, default 2048, divisor.
// - Direction flip negates speed and count direction.
// - Load angle is motor angle times out/in.
// - Load equals motor at start; multi-turn restores.
// - Absolute angle relative to zero offset.
// - Report motor angle and load angle.
// - Turn counter starts from zero.
// - Multi-turn: 32-bit counter, low 12 match sensor.
// - Align absolute reading to incremental position.
// - Report alignment state codes 0 to 9.
// - Retry alignment, then hold failed state.
// - Restart failed alignment; clear retry when done.
// - Flag error on start after failed alignment.
// - Edge tally counts every edge, clearable.
// - Analogue sensor supply select 5V or 10V.
// - Report mechanical speed in rpm.
// - Quadrature direction from both channel states.
// - Speed hertz is edges/s over 4*lines.
`timescale 1ns/100ps
`include "shaft_position_feedback_consts.svh"
module shaft_position_feedback
    import shaft_position_feedback_pkg::*;
#(
    parameter int WINDOW_CYC = `SPEED_WINDOW_CYC,
    parameter int FILTER_CYC = `FILTER_CYC,
    parameter int ALIGN_TRIES = `ALIGN_TRIES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chanA,
    input wire logic chanB,
    input wire logic [1:0] fittedCard,
    input wire logic cfgWrite,
    input wire logic [3:0] sensorKindIn,
    input wire logic [17:0] linesIn,
    input wire logic dirFlipIn,
    input wire logic [31:0] gearInIn,
    input wire logic signed [31:0] gearOutIn,
    input wire logic [21:0] zeroOffsetIn,
    input wire logic supplySelectIn,
    input wire logic edgeClear,
    input wire logic alignRetry,
    input wire logic driveRunning,
    input wire logic motorMoving,
    input wire logic driveStartReq,
    input wire logic absValid,
    input wire logic [19:0] absPosition,
    input wire logic [11:0] absTurns,
    input wire logic absFault,
    output logic kindError,
    output logic startError,
    output logic retryClear,
    output logic analogSupply10V,
    output logic [3:0] alignState,
    output logic [21:0] motorAngle,
    output logic [21:0] loadAngle,
    output logic [31:0] turnCount,
    output logic [31:0] edgeTally,
    output logic signed [31:0] speedRpm,
    output logic signed [31:0] speedHz
);
    logic [3:0] kindQ;
    logic [17:0] linesQ;
    logic dirFlipQ;
    logic [31:0] gearInQ;
    logic signed [31:0] gearOutQ;
    logic [21:0] offsetQ;
    logic cfgChangeQ;
    logic [1:0] syncMeta;
    logic [1:0] syncQ;
    logic [1:0] chanQ;
    logic [1:0] chanPrevQ;
    logic [19:0] posQ;
    logic [31:0] turnQ;
    logic stepFwd;
    logic stepBack;
    logic [19:0] fullCount;
    logic isAbs;
    logic alignLoad;
    align_fsm_t alignQ;
    logic [7:0] triesQ;
    logic [19:0] alignDiff;
    logic [31:0] winCntQ;
    logic signed [31:0] winEdgesQ;
    logic signed [31:0] speedEdgesQ;
    div_job_t jobQ;
    logic [95:0] dvdQ;
    logic [95:0] quoQ;
    logic [31:0] dvsQ;
    logic [32:0] remQ;
    logic [6:0] bitQ;
    logic busyQ;
    logic negQ;
    logic signed [95:0] loadQuoQ;
    logic [32:0] remShift;
    logic signed [63:0] motorTotal;
    logic signed [95:0] loadProduct;
    logic [95:0] startNum;
    logic [31:0] startDen;
    logic startNeg;

    // Settings hold their defaults until first written; out-of-range lines, gear and offset values are clamped, kind codes are kept as written.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kindQ <= `KIND_DEFAULT;
            linesQ <= `LINES_DEFAULT;
            dirFlipQ <= 1'b0;
            gearInQ <= `GEAR_DEFAULT;
            gearOutQ <= `GEAR_DEFAULT;
            offsetQ <= 22'h000000;
            analogSupply10V <= 1'b0;
            cfgChangeQ <= 1'b0;
        end else begin
            cfgChangeQ <= 1'b0;
            if (cfgWrite) begin
                kindQ <= sensorKindIn;
                if (linesIn < `LINES_MIN) begin
                    linesQ <= `LINES_MIN;
                end else begin
                    linesQ <= linesIn;
                end
                dirFlipQ <= dirFlipIn;
                gearInQ <= (gearInIn < `GEAR_IN_MIN) ? `GEAR_IN_MIN :
                    (gearInIn > `GEAR_LIMIT) ? `GEAR_LIMIT : gearInIn;
                gearOutQ <= (gearOutIn > $signed(`GEAR_LIMIT)) ? $signed(`GEAR_LIMIT) :
                    (gearOutIn < -$signed(`GEAR_LIMIT)) ? -$signed(`GEAR_LIMIT) : gearOutIn;
                offsetQ <= (zeroOffsetIn > `DEG_FULL) ? `DEG_FULL : zeroOffsetIn;
                analogSupply10V <= supplySelectIn;
                cfgChangeQ <= (sensorKindIn != kindQ) || (linesIn != linesQ) ||
                    (dirFlipIn != dirFlipQ) || (zeroOffsetIn != offsetQ);
            end
        end
    end

    // Hardware check: a kind needs its matching card, and codes above 9 are invalid.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kindError <= 1'b0;
        end else if (kindQ > `KIND_LAST) begin
            kindError <= 1'b1;
        end else if (kindQ == KIND_RESOLVER) begin
            kindError <= (fittedCard != `CARD_RESOLVER);
        end else if (kindQ >= KIND_SINCOS_INC) begin
            kindError <= (fittedCard != `CARD_ANALOG);
        end else begin
            kindError <= (fittedCard != `CARD_PULSE);
        end
    end

    // Each channel passes two flops, then must stay steady before it is accepted.
    // The filter costs a little latency but stops contact bounce double-counting.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : gChan
            logic [7:0] stableQ;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    syncMeta[ch] <= 1'b0;
                    syncQ[ch] <= 1'b0;
                    chanQ[ch] <= 1'b0;
                    stableQ <= 8'h00;
                end else begin
                    syncMeta[ch] <= (ch == 0) ? chanA : chanB;
                    syncQ[ch] <= syncMeta[ch];
                    if (syncQ[ch] == chanQ[ch]) begin
                        stableQ <= 8'h00;
                    end else if (stableQ == 8'(FILTER_CYC - 1)) begin
                        chanQ[ch] <= syncQ[ch];
                        stableQ <= 8'h00;
                    end else begin
                        stableQ <= stableQ + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // Step decode per sensor kind; analogue kinds fall through to the quadrature decode of channels A and B.
    always_comb begin
        logic up;
        logic dn;
        up = 1'b0;
        dn = 1'b0;
        case (kindQ)
            KIND_CLKDIR_SE, KIND_CLKDIR_DIFF: begin
                up = (chanQ[0] != chanPrevQ[0]) && !chanQ[1];
                dn = (chanQ[0] != chanPrevQ[0]) && chanQ[1];
            end
            KIND_CLK_SE, KIND_CLK_DIFF: begin
                up = (chanQ[0] != chanPrevQ[0]);
            end
            default: begin
                // A leading B by a quarter cycle is forward rotation.
                up = (chanQ != chanPrevQ) && (chanQ[0] ^ chanPrevQ[1]) && !(chanQ == ~chanPrevQ);
                dn = (chanQ != chanPrevQ) && (chanQ[1] ^ chanPrevQ[0]) && !(chanQ == ~chanPrevQ);
            end
        endcase
        stepFwd = dirFlipQ ? dn : up;
        stepBack = dirFlipQ ? up : dn;
    end

    assign fullCount = 20'(linesQ) * 20'(`EDGES_PER_LINE);
    assign isAbs = (kindQ == KIND_ABS_SINGLE) || (kindQ == KIND_ABS_MULTI);

    // Edge tally counts every accepted edge regardless of direction.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanPrevQ <= 2'h0;
            edgeTally <= 32'h00000000;
        end else begin
            chanPrevQ <= chanQ;
            if (edgeClear) begin
                edgeTally <= 32'h00000000;
            end else if (stepFwd || stepBack) begin
                edgeTally <= edgeTally + 32'h00000001;
            end
        end
    end

    // Position within the turn and whole turns; alignment overwrites the position, and for multi-turn kinds the low 12 turn bits.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            posQ <= 20'h00000;
            turnQ <= 32'h00000000;
        end else if (alignLoad) begin
            posQ <= (absPosition < fullCount) ? absPosition : 20'h00000;
            if (kindQ == KIND_ABS_MULTI) begin
                turnQ[`ABS_TURN_BITS-1:0] <= absTurns;
            end
        end else if (stepFwd) begin
            if (posQ >= fullCount - 20'h00001) begin
                posQ <= 20'h00000;
                turnQ <= turnQ + 32'h00000001;
            end else begin
                posQ <= posQ + 20'h00001;
            end
        end else if (stepBack) begin
            if (posQ == 20'h00000) begin
                posQ <= fullCount - 20'h00001;
                turnQ <= turnQ - 32'h00000001;
            end else begin
                posQ <= posQ - 20'h00001;
            end
        end
    end
    assign turnCount = turnQ;

    // Signed edge sum over a fixed window gives the speed sample.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            winCntQ <= 32'h00000000;
            winEdgesQ <= 32'sh00000000;
            speedEdgesQ <= 32'sh00000000;
        end else if (winCntQ == 32'(WINDOW_CYC - 1)) begin
            winCntQ <= 32'h00000000;
            speedEdgesQ <= winEdgesQ + (stepFwd ? 32'sh1 : stepBack ? -32'sh1 : 32'sh0);
            winEdgesQ <= 32'sh00000000;
        end else begin
            winCntQ <= winCntQ + 32'h00000001;
            winEdgesQ <= winEdgesQ + (stepFwd ? 32'sh1 : stepBack ? -32'sh1 : 32'sh0);
        end
    end

    // Operands of each divider job; signs are stripped here and restored on finish.
    assign motorTotal = $signed(64'(signed'(turnQ))) * $signed(64'(`DEG_FULL)) +
        $signed(64'(motorAngle));
    assign loadProduct = 96'(motorTotal) * 96'(gearOutQ);
    always_comb begin
        startNum = 96'h0;
        startDen = 32'(fullCount);
        startNeg = 1'b0;
        case (jobQ)
            JOB_ANGLE: startNum = 96'(posQ) * 96'(`DEG_FULL);
            JOB_LOAD_DIV: begin
                startNeg = loadProduct[95];
                startNum = startNeg ? 96'(-loadProduct) : 96'(loadProduct);
                startDen = gearInQ;
            end
            JOB_LOAD_MOD: begin
                startNeg = loadQuoQ[95];
                startNum = startNeg ? 96'(-loadQuoQ) : 96'(loadQuoQ);
                startDen = 32'(`DEG_FULL);
            end
            JOB_RPM, JOB_HZ: begin
                startNeg = speedEdgesQ[31];
                startNum = 96'(startNeg ? -speedEdgesQ : speedEdgesQ) *
                    ((jobQ == JOB_RPM) ? 96'(`RPM_FACTOR) : 96'(`HZ_FACTOR));
            end
            default: startNum = 96'h0;
        endcase
    end
    assign remShift = {remQ[31:0], dvdQ[95]};

    // Restoring divider, one quotient bit per cycle, jobs taken round robin.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            jobQ <= JOB_ANGLE;
            busyQ <= 1'b0;
            dvdQ <= 96'h0;
            dvsQ <= 32'h1;
            quoQ <= 96'h0;
            remQ <= 33'h0;
            bitQ <= 7'h00;
            negQ <= 1'b0;
            loadQuoQ <= 96'sh0;
            motorAngle <= 22'h000000;
            loadAngle <= 22'h000000;
            speedRpm <= 32'sh0;
            speedHz <= 32'sh0;
        end else if (!busyQ) begin
            busyQ <= 1'b1;
            dvdQ <= startNum;
            dvsQ <= startDen;
            negQ <= startNeg;
            quoQ <= 96'h0;
            remQ <= 33'h0;
            bitQ <= 7'd96;
        end else if (bitQ != 7'h00) begin
            bitQ <= bitQ - 7'h01;
            dvdQ <= {dvdQ[94:0], 1'b0};
            if (remShift >= {1'b0, dvsQ}) begin
                remQ <= remShift - {1'b0, dvsQ};
                quoQ <= {quoQ[94:0], 1'b1};
            end else begin
                remQ <= remShift;
                quoQ <= {quoQ[94:0], 1'b0};
            end
        end else begin
            busyQ <= 1'b0;
            case (jobQ)
                JOB_ANGLE: begin
                    // Shift by the zero offset and wrap into one turn.
                    if (isAbs) begin
                        motorAngle <= (quoQ[21:0] >= offsetQ) ? quoQ[21:0] - offsetQ :
                            quoQ[21:0] + `DEG_FULL - offsetQ;
                    end else begin
                        motorAngle <= quoQ[21:0];
                    end
                    jobQ <= JOB_LOAD_DIV;
                end
                JOB_LOAD_DIV: begin
                    loadQuoQ <= negQ ? -$signed(quoQ) : $signed(quoQ);
                    jobQ <= JOB_LOAD_MOD;
                end
                JOB_LOAD_MOD: begin
                    loadAngle <= (negQ && remQ != 33'h0) ? `DEG_FULL - remQ[21:0] :
                        remQ[21:0];
                    jobQ <= JOB_RPM;
                end
                JOB_RPM: begin
                    speedRpm <= negQ ? -$signed(quoQ[31:0]) : $signed(quoQ[31:0]);
                    jobQ <= JOB_HZ;
                end
                default: begin
                    speedHz <= negQ ? -$signed(quoQ[31:0]) : $signed(quoQ[31:0]);
                    jobQ <= JOB_ANGLE;
                end
            endcase
        end
    end

    assign alignDiff = (absPosition > posQ) ? absPosition - posQ : posQ - absPosition;
    assign alignLoad = (alignQ == AL_RUN) && absValid;

    // Alignment sequence: checks, load, verify, with bounded retries.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alignQ <= AL_OFF;
            alignState <= `CODE_NOT_REQUIRED;
            triesQ <= 8'h00;
            retryClear <= 1'b0;
        end else begin
            retryClear <= 1'b0;
            if (!isAbs) begin
                alignQ <= AL_OFF;
                alignState <= `CODE_NOT_REQUIRED;
            end else if (cfgChangeQ || (alignQ == AL_FAIL && alignRetry)) begin
                alignQ <= AL_CHECK;
                triesQ <= 8'h00;
            end else begin
                case (alignQ)
                    AL_OFF: begin
                        alignQ <= AL_CHECK;
                        triesQ <= 8'h00;
                    end
                    AL_CHECK: begin
                        if (driveRunning) begin
                            alignState <= `CODE_DRIVE_RUNNING;
                        end else if (motorMoving) begin
                            alignState <= `CODE_MOTOR_MOVING;
                        end else if (absFault) begin
                            alignState <= `CODE_SENSOR_FAULT;
                        end else begin
                            alignState <= `CODE_IN_PROGRESS;
                            alignQ <= AL_RUN;
                        end
                    end
                    AL_RUN: begin
                        if (absValid) begin
                            alignState <= `CODE_IDENTIFYING;
                            alignQ <= AL_VERIFY;
                        end
                    end
                    AL_VERIFY: begin
                        if (absValid) begin
                            if (alignDiff <= 20'(`ALIGN_TOL)) begin
                                alignQ <= AL_DONE;
                                alignState <= (alignDiff > 20'(`ALIGN_TOL / 2)) ?
                                    `CODE_WARNING : `CODE_COMPLETED;
                                retryClear <= alignRetry;
                            end else if (triesQ == 8'(ALIGN_TRIES - 1)) begin
                                alignQ <= AL_FAIL;
                                alignState <= `CODE_FAILED;
                            end else begin
                                triesQ <= triesQ + 8'h01;
                                alignQ <= AL_CHECK;
                            end
                        end
                    end
                    AL_DONE: begin
                        if (absFault) begin
                            alignState <= `CODE_LOST;
                        end
                    end
                    AL_FAIL: alignState <= `CODE_FAILED;
                    default: alignQ <= AL_OFF;
                endcase
            end
        end
    end

    // A start request after failed alignment is refused with an error level.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startError <= 1'b0;
        end else if (alignQ != AL_FAIL) begin
            startError <= 1'b0;
        end else if (driveStartReq) begin
            startError <= 1'b1;
        end
    end
endmodule : shaft_position_feedback

//--- test/shaft_sensor_model.sv
// Purpose: Behavioural quadrature shaft sensor.
// Assumes: Steps are spaced seven clocks, wider than the input filter.
// Notes: Channels hold their level between steps, as a real sensor does.
`timescale 1ns/100ps
module shaft_sensor_model (
    input wire logic clk,
    output logic chanA,
    output logic chanB
);
    logic [1:0] phase = 2'h0;
    // Gray order, so channel A leads channel B when turning forward.
    assign chanA = phase[1] ^ phase[0];
    assign chanB = phase[1];
    // Spacing keeps every level longer than the filter span.
    task automatic step(input logic fwd, input int count);
        repeat (count) begin
            @(negedge clk);
            phase = fwd ? phase + 2'h1 : phase - 2'h1;
            repeat (6) @(negedge clk);
        end
    endtask : step
endmodule : shaft_sensor_model

//--- test/shaft_position_feedback_checker.sv
// Purpose: Port-level checks of the shaft position feedback block.
// Assumes: Settings are written no closer than five cycles apart.
// Notes: Angle and speed results are not watched here.
`timescale 1ns/100ps
module shaft_position_feedback_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] fittedCard,
    input wire logic cfgWrite,
    input wire logic [3:0] sensorKindIn,
    input wire logic supplySelectIn,
    input wire logic edgeClear,
    input wire logic alignRetry,
    input wire logic driveStartReq,
    input wire logic kindError,
    input wire logic startError,
    input wire logic retryClear,
    input wire logic analogSupply10V,
    input wire logic [3:0] alignState,
    input wire logic [31:0] edgeTally
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A pulse card only fits the six pulse kinds.
    chk_kind_flag: assert property (cfgWrite && fittedCard == 2'h1 |->
        ##3 kindError == ($past(sensorKindIn, 3) > 4'h5)) else $error("kind flag wrong");
    chk_supply_take: assert property (cfgWrite |->
        ##2 analogSupply10V == $past(supplySelectIn, 2)) else $error("supply select wrong");
    chk_tally_clear: assert property (edgeClear [*2] |->
        edgeTally == 32'h0) else $error("tally not cleared");
    chk_tally_step: assert property ($changed(edgeTally) |->
        edgeTally == $past(edgeTally) + 32'h1 || edgeTally == 32'h0) else $error("tally jump");
    chk_fail_hold: assert property (alignState == 4'h8 && !alignRetry && !cfgWrite |->
        ##1 alignState == 4'h8) else $error("failed state left");
    chk_start_flag: assert property (alignState == 4'h8 && driveStartReq |->
        ##[1:2] startError) else $error("start error missing");
    chk_retry_pulse: assert property (retryClear |->
        alignRetry ##1 !retryClear) else $error("retry clear wrong");
    chk_plain_kind: assert property (cfgWrite && sensorKindIn < 4'h7 |->
        ##[2:4] alignState == 4'h0) else $error("align code not zero");
    cover property (alignState == 4'h6);
    cover property (alignState == 4'h8);
    cover property (kindError);
endmodule : shaft_position_feedback_checker

//--- test/tb_top.sv
// Purpose: Self-checking bench for the shaft position feedback block.
// Assumes: Inputs change at the falling edge; gear and offset stay fixed.
// Notes: Short lines setting keeps a full turn within a few thousand cycles.
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, cfgWrite, flip, supply, edgeClear, alignRetry, chanA, chanB;
    logic driveRunning, motorMoving, driveStartReq, absValid, absFault;
    logic kindError, startError, retryClear, supply10V;
    logic [1:0] card;
    logic [3:0] kind, alignState;
    logic [17:0] lines;
    logic [19:0] absPosition;
    logic [11:0] absTurns;
    logic [21:0] motorAngle, loadAngle;
    logic [31:0] turnCount, edgeTally, speedRpm, speedHz;
    int failures = 0;
    int cmpCount = 0;
    shaft_position_feedback #(.WINDOW_CYC(100)) DUT (.clk, .rst_n, .chanA, .chanB,
        .fittedCard(card), .cfgWrite, .sensorKindIn(kind), .linesIn(lines), .dirFlipIn(flip),
        .gearInIn(32'h00000001), .gearOutIn(32'sh00000001), .zeroOffsetIn(22'h000000),
        .supplySelectIn(supply), .edgeClear, .alignRetry, .driveRunning, .motorMoving,
        .driveStartReq, .absValid, .absPosition, .absTurns, .absFault, .kindError,
        .startError, .retryClear, .analogSupply10V(supply10V), .alignState, .motorAngle,
        .loadAngle, .turnCount, .edgeTally, .speedRpm, .speedHz);
    shaft_sensor_model sensor (.clk, .chanA, .chanB);
    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic cfg(input logic [3:0] k, input logic f, input logic s);
        kind = k;
        flip = f;
        supply = s;
        cfgWrite = 1'b1;
        tick(1);
        cfgWrite = 1'b0;
        tick(4);
    endtask : cfg
    task automatic abs_read(input logic [19:0] p);
        absPosition = p;
        absValid = 1'b1;
        tick(1);
        absValid = 1'b0;
        tick(20);
    endtask : abs_read
    task automatic test_reset;
        check("edgeTally", edgeTally, 32'h0);
        check("turnCount", turnCount, 32'h0);
        check("alignState", alignState, 4'h0);
        check("supply10V", supply10V, 1'b0);
        check("kindError", kindError, 1'b0);
        $display("reset test done");
    endtask : test_reset
    task automatic test_kinds;
        for (int k = 0; k < 11; k++) begin
            cfg(4'(k), 1'b0, k[0]);
            check("kindError", kindError, k > 5);
            check("supply10V", supply10V, k[0]);
        end
        $display("kind test done");
    endtask : test_kinds
    task automatic test_edges;
        lines = 18'h000FA;
        cfg(4'h3, 1'b0, 1'b0);
        sensor.step(1'b1, 1002);
        tick(4);
        check("edgeTally", edgeTally, 32'd1002);
        check("turnCount", turnCount, 32'h1);
        sensor.step(1'b0, 4);
        tick(4);
        check("edgeTally", edgeTally, 32'd1006);
        check("turnCount", turnCount, 32'h0);
        sensor.step(1'b1, 4);
        cfg(4'h3, 1'b1, 1'b0);
        sensor.step(1'b1, 4);
        tick(4);
        check("turnCount", turnCount, 32'h0);
        tick(700);
        check("motorAngle", motorAngle, 32'h36D260);
        edgeClear = 1'b1;
        tick(3);
        check("edgeTally", edgeTally, 32'h0);
        edgeClear = 1'b0;
        cfg(4'h3, 1'b0, 1'b0);
        $display("edge test done");
    endtask : test_edges
    task automatic test_align;
        card = 2'h2;
        motorMoving = 1'b1;
        absTurns = 12'h005;
        cfg(4'h8, 1'b0, 1'b0);
        check("alignState", alignState, 4'h2);
        motorMoving = 1'b0;
        tick(5);
        check("alignState", alignState, 4'h4);
        abs_read(20'h00000);
        check("alignState", alignState, 4'h5);
        check("turnLow", turnCount[11:0], 12'h005);
        abs_read(20'h00000);
        check("alignState", alignState, 4'h6);
        check("kindError", kindError, 1'b0);
        cfg(4'h7, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            abs_read(i[0] ? 20'h00064 : 20'h00000);
        end
        check("alignState", alignState, 4'h8);
        driveStartReq = 1'b1;
        tick(3);
        driveStartReq = 1'b0;
        check("startError", startError, 1'b1);
        alignRetry = 1'b1;
        tick(5);
        abs_read(20'h00000);
        abs_read(20'h00000);
        alignRetry = 1'b0;
        check("alignState", alignState, 4'h6);
        check("startError", startError, 1'b0);
        $display("align test done");
    endtask : test_align
    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // Main sequence; all inputs are set at time zero and reset spans twelve cycles.
    initial begin
        {rst_n, cfgWrite, flip, supply, edgeClear, alignRetry, driveRunning} = '0;
        {motorMoving, driveStartReq, absValid, absFault, absPosition, absTurns} = '0;
        card = 2'h1;
        kind = 4'h3;
        lines = 18'h00800;
        repeat (12) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        tick(2);
        test_reset();
        test_kinds();
        test_edges();
        test_align();
        complete_run();
    end
    // Watchdog well beyond the expected run of about eight thousand cycles.
    initial begin
        #500000;
        failures++;
        complete_run();
    end
endmodule : tb_top
bind shaft_position_feedback shaft_position_feedback_checker chk (.clk, .rst_n, .fittedCard,
    .cfgWrite, .sensorKindIn, .supplySelectIn, .edgeClear, .alignRetry, .driveStartReq,
    .kindError, .startError, .retryClear, .analogSupply10V, .alignState, .edgeTally);
